// [verilog/gpib_ctl_pkg.sv]
// Shared constants and carrier types for the bus controller block.
// Assumes a single 50 MHz system clock and APB register access.
package gpib_ctl_pkg;
   // APB byte addresses
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CMD    = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   localparam logic [7:0] ADDR_CTRL   = 8'h10;
   localparam logic [7:0] ADDR_COUNT  = 8'h14;
   localparam logic [7:0] ADDR_RESULT = 8'h18;
   // Control register fields
   localparam int CTRL_COUNT_EN = 0;
   localparam int CTRL_REN      = 1;
   localparam int CTRL_TCS      = 2;
   localparam int CTRL_TCA      = 3;
   localparam int CTRL_PPOLL    = 4;
   localparam int CTRL_SIC      = 5;
   localparam int CTRL_RELEASE  = 6;
   localparam int CTRL_TAKE_CIC = 7;
   // Mask register fields
   localparam int MASK_IBE = 0;
   localparam int MASK_OBF = 1;
   // Reset values
   localparam logic [7:0]  MASK_RST = 8'h00;
   localparam logic [7:0]  CTRL_RST = 8'h00;
   // Sync divider and count sampling
   localparam int SYNC_DIV       = 15;
   localparam int SAMPLE_CYCLES  = 3;
   localparam logic [3:0] SYNC_LAST = 4'(SYNC_DIV - 1);
   localparam logic [5:0] SAMPLE_LAST = 6'(SYNC_DIV * SAMPLE_CYCLES - 1);
   localparam logic [3:0] SYNC_HALF = 4'(SYNC_DIV / 2);
   // Clear-latch pulse length in ns, and cycles at 20 ns
   localparam int CLK_PERIOD_NS  = 20;
   localparam int CLEAR_LATCH_PULSE_PULSE_NS  = 100;
   localparam logic [3:0] CLEAR_LATCH_PULSE_CYCLES = 4'((CLEAR_LATCH_PULSE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef struct packed {
      logic attention;
      logic end_identify;
      logic data_valid;
      logic remote_enable;
      logic iface_clear;
   } bus_drive_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_TCS    = 3'b001,
      ST_TCA    = 3'b010,
      ST_PPOLL  = 3'b011,
      ST_SIC    = 3'b100,
      ST_DONE   = 3'b101
   } task_state_t;
endpackage

// [verilog/gpib_controller_function.sv]
// Bus controller function: APB host port, bus management lines, event counter.
// Assumes APB master on i_sys_clk; bus line inputs synchronous to the clock.
//
// Behaviour
// - When not system controller, sense interface clear on the latched input.
// - Address selects data or status on reads, data or command on writes.
// - Sync output runs at clock divided by fifteen.
// - While in charge, a true service request raises the special interrupt.
// - Clear-latch pulse low except after reset, pulsed high when latched clear is seen.
// - Attention driven out during synchronous and asynchronous take control.
// - Attention monitor input used during transfer of control.
// - Each enabled high-to-low count edge seen between two samples increments counter by one.
// - Count input sampled once every three instruction cycles.
// - Data valid driven during parallel poll and synchronous take control.
// - Input buffer empty interrupt when enabled in mask.
// - Output buffer full interrupt when enabled in mask.
// - End-identify driven with attention for a parallel poll.
// - Special interrupt raised for events host did not start.
// - Task complete raised when task done and result in buffer.
// - In-charge output sets service request transceiver direction.
// - As system controller, drive interface clear; read switch input.
// - Remote enable line driven from host control while system controller switch is set.
// - Chip select gates access; reset sets known state.
`timescale 1ns/1ps
module gpib_controller_function (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        i_latched_clear_in,
   input  wire logic        i_attention_monitor_in,
   input  wire logic        i_system_controller_switch,
   input  wire logic        i_service_request,
   input  wire logic        i_count,
   input  wire logic        i_end_identify_line,
   input  wire logic        i_data_valid,
   output logic             o_sync,
   output logic             o_clear_latch_pulse,
   output logic             o_attention_drive_out,
   output logic             o_end_identify_line,
   output logic             o_end_identify_oe,
   output logic             o_data_valid,
   output logic             o_data_valid_oe,
   output logic             o_remote_enable,
   output logic             o_iface_clear,
   output logic             o_iface_clear_oe,
   output logic             o_in_charge_out,
   output logic             o_input_buffer_empty_irq,
   output logic             o_output_buffer_full_irq,
   output logic             o_special_irq,
   output logic             o_task_complete_irq
);
   logic [7:0]  in_data_q;
   logic        in_full_q;
   logic        in_is_cmd_q;
   logic [7:0]  out_data_q;
   logic        out_full_q;
   logic [7:0]  mask_q;
   logic [7:0]  ctrl_q;
   logic [15:0] count_q;
   logic [3:0]  sync_cnt_q;
   logic [5:0]  sample_cnt_q;
   logic        count_prev_q;
   logic        sync_q;
   logic        cic_q;
   logic        clr_seen_q;
   logic [3:0]  clear_latch_pulse_cnt_q;
   logic        srq_ev_q;
   logic        ifc_ev_q;
   logic        tc_q;
   gpib_ctl_pkg::task_state_t state_q;
   gpib_ctl_pkg::bus_drive_t drv;

   // APB decode
   wire access   = psel && penable;
   wire wr_en    = access && pwrite;
   wire rd_en    = access && !pwrite;
   wire a_data   = paddr == gpib_ctl_pkg::ADDR_DATA;
   wire a_status = paddr == gpib_ctl_pkg::ADDR_STATUS;
   wire a_cmd    = paddr == gpib_ctl_pkg::ADDR_CMD;
   wire a_mask   = paddr == gpib_ctl_pkg::ADDR_MASK;
   wire a_ctrl   = paddr == gpib_ctl_pkg::ADDR_CTRL;
   wire a_count  = paddr == gpib_ctl_pkg::ADDR_COUNT;
   wire a_result = paddr == gpib_ctl_pkg::ADDR_RESULT;
   wire mapped   = a_data | a_status | a_cmd | a_mask | a_ctrl | a_count | a_result;
   wire wr_buf   = wr_en && (a_data || a_cmd);
   wire rd_data  = rd_en && a_data;
   wire wr_mask  = wr_en && a_mask;
   wire wr_ctrl  = wr_en && a_ctrl;
   wire wr_res   = wr_en && a_result;
   wire rd_stat  = rd_en && a_status;

   // Status byte shows buffer, ownership and event state
   wire [7:0] status = {tc_q, ifc_ev_q, srq_ev_q, i_system_controller_switch,
                        cic_q, state_q != gpib_ctl_pkg::ST_IDLE, out_full_q, in_full_q};

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         if (a_data)   prdata = {24'h00_0000, out_data_q};
         if (a_status) prdata = {24'h00_0000, status};
         if (a_mask)   prdata = {24'h00_0000, mask_q};
         if (a_ctrl)   prdata = {24'h00_0000, ctrl_q};
         if (a_count)  prdata = {16'h0000, count_q};
      end
   end

   // Host input buffer: data or command by address
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         in_data_q   <= 8'h00;
         in_full_q   <= 1'b0;
         in_is_cmd_q <= 1'b0;
      end else if (wr_buf) begin
         in_data_q   <= pwdata[7:0];
         in_is_cmd_q <= a_cmd;
         in_full_q   <= 1'b1;
      end else if (in_full_q) begin
         in_full_q   <= 1'b0;                                    // Consumed next cycle
      end
   end

   // Output buffer loaded by finished tasks or result writes
   wire task_done = state_q == gpib_ctl_pkg::ST_DONE;
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         out_data_q <= 8'h00;
         out_full_q <= 1'b0;
      end else if (task_done) begin
         out_data_q <= status;
         out_full_q <= 1'b1;
      end else if (wr_res) begin
         out_data_q <= pwdata[7:0];
         out_full_q <= 1'b1;
      end else if (rd_data) begin
         out_full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         mask_q <= gpib_ctl_pkg::MASK_RST;
         ctrl_q <= gpib_ctl_pkg::CTRL_RST;
      end else begin
         if (wr_mask) mask_q <= pwdata[7:0];
         if (wr_ctrl) ctrl_q <= pwdata[7:0];
         else if (state_q != gpib_ctl_pkg::ST_IDLE) ctrl_q[5:2] <= 4'h0;
      end
   end

   // Sync divider and count sampling cadence
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sync_cnt_q   <= 4'h0;
         sync_q       <= 1'b0;
         sample_cnt_q <= 6'h00;
      end else begin
         sync_cnt_q   <= (sync_cnt_q == gpib_ctl_pkg::SYNC_LAST) ? 4'h0 : sync_cnt_q + 4'h1;
         sync_q       <= sync_cnt_q < gpib_ctl_pkg::SYNC_HALF;
         sample_cnt_q <= (sample_cnt_q == gpib_ctl_pkg::SAMPLE_LAST) ? 6'h00
                         : sample_cnt_q + 6'h01;
      end
   end
   assign o_sync = sync_q;

   // Slow sampling means short pulses on the count pin are missed
   wire sample_now = sample_cnt_q == gpib_ctl_pkg::SAMPLE_LAST;
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         count_prev_q <= 1'b0;
         count_q      <= 16'h0000;
      end else if (sample_now) begin
         count_prev_q <= i_count;
         if (ctrl_q[gpib_ctl_pkg::CTRL_COUNT_EN] && count_prev_q && !i_count)
            count_q <= count_q + 16'h0001;
      end
   end

   // Transfer-of-control sequencer
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= gpib_ctl_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            gpib_ctl_pkg::ST_IDLE: begin
               if (ctrl_q[gpib_ctl_pkg::CTRL_SIC] && i_system_controller_switch)
                  state_q <= gpib_ctl_pkg::ST_SIC;
               else if (ctrl_q[gpib_ctl_pkg::CTRL_TCA] && cic_q)
                  state_q <= gpib_ctl_pkg::ST_TCA;
               else if (ctrl_q[gpib_ctl_pkg::CTRL_TCS] && cic_q)
                  state_q <= gpib_ctl_pkg::ST_TCS;
               else if (ctrl_q[gpib_ctl_pkg::CTRL_PPOLL] && cic_q)
                  state_q <= gpib_ctl_pkg::ST_PPOLL;
            end
            // Wait for the bus to show attention asserted
            gpib_ctl_pkg::ST_TCS,
            gpib_ctl_pkg::ST_TCA: begin
               if (i_attention_monitor_in) state_q <= gpib_ctl_pkg::ST_DONE;
            end
            gpib_ctl_pkg::ST_PPOLL: begin
               if (!i_data_valid) state_q <= gpib_ctl_pkg::ST_DONE;
            end
            gpib_ctl_pkg::ST_SIC: begin
               state_q <= gpib_ctl_pkg::ST_DONE;
            end
            gpib_ctl_pkg::ST_DONE: begin
               state_q <= gpib_ctl_pkg::ST_IDLE;
            end
            default: state_q <= gpib_ctl_pkg::ST_IDLE;
         endcase
      end
   end

   // Ownership of the bus
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         cic_q <= 1'b0;
      end else if (state_q == gpib_ctl_pkg::ST_SIC) begin
         cic_q <= 1'b1;
      end else if (wr_ctrl && pwdata[gpib_ctl_pkg::CTRL_RELEASE]) begin
         cic_q <= 1'b0;
      end else if (wr_ctrl && pwdata[gpib_ctl_pkg::CTRL_TAKE_CIC]) begin
         cic_q <= 1'b1;
      end else if (clr_seen_q) begin
         cic_q <= 1'b0;                                          // Clear from elsewhere drops charge
      end
   end
   assign o_in_charge_out = cic_q;

   // Latched clear from another system controller
   wire clr_detect = i_latched_clear_in && !i_system_controller_switch;
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         clr_seen_q <= 1'b0;
         clear_latch_pulse_cnt_q <= gpib_ctl_pkg::CLEAR_LATCH_PULSE_CYCLES;
      end else begin
         clr_seen_q <= clr_detect && clear_latch_pulse_cnt_q == 4'h0;
         if (clr_detect && clear_latch_pulse_cnt_q == 4'h0)
            clear_latch_pulse_cnt_q <= gpib_ctl_pkg::CLEAR_LATCH_PULSE_CYCLES;
         else if (clear_latch_pulse_cnt_q != 4'h0)
            clear_latch_pulse_cnt_q <= clear_latch_pulse_cnt_q - 4'h1;
      end
   end
   assign o_clear_latch_pulse = clear_latch_pulse_cnt_q != 4'h0;

   // Unsolicited events: set wins over status-read clear
   wire srq_set = cic_q && i_service_request;
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         srq_ev_q <= 1'b0;
         ifc_ev_q <= 1'b0;
         tc_q     <= 1'b0;
      end else begin
         srq_ev_q <= srq_set || (srq_ev_q && !rd_stat);
         ifc_ev_q <= clr_seen_q || (ifc_ev_q && !rd_stat);
         tc_q     <= task_done || (tc_q && !rd_data);
      end
   end
   assign o_special_irq       = srq_ev_q || ifc_ev_q;
   assign o_task_complete_irq = tc_q && out_full_q;

   assign o_input_buffer_empty_irq = !in_full_q && mask_q[gpib_ctl_pkg::MASK_IBE];
   assign o_output_buffer_full_irq = out_full_q && mask_q[gpib_ctl_pkg::MASK_OBF];

   // Bus line drive
   always_comb begin
      drv = '0;
      drv.attention     = state_q == gpib_ctl_pkg::ST_TCS ||
                          state_q == gpib_ctl_pkg::ST_TCA ||
                          state_q == gpib_ctl_pkg::ST_PPOLL;
      drv.end_identify  = state_q == gpib_ctl_pkg::ST_PPOLL;
      drv.data_valid    = state_q == gpib_ctl_pkg::ST_PPOLL ||
                          state_q == gpib_ctl_pkg::ST_TCS;
      drv.remote_enable = ctrl_q[gpib_ctl_pkg::CTRL_REN] && i_system_controller_switch;
      drv.iface_clear   = state_q == gpib_ctl_pkg::ST_SIC;
   end
   assign o_attention_drive_out = drv.attention;
   assign o_end_identify_line   = drv.end_identify;
   assign o_end_identify_oe     = drv.end_identify;
   assign o_data_valid          = drv.data_valid;
   assign o_data_valid_oe       = drv.data_valid;
   assign o_remote_enable       = drv.remote_enable;
   assign o_iface_clear         = drv.iface_clear;
   assign o_iface_clear_oe      = i_system_controller_switch;

   wire unused_ok = &{1'b0, in_data_q, in_is_cmd_q, i_end_identify_line, pwdata[31:8]};
endmodule

// [testbench/gpib_ctl_properties.sv]
// Port checker for the bus controller, bound into the design top.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module gpib_ctl_properties (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   input wire logic i_latched_clear_in,
   input wire logic i_system_controller_switch,
   input wire logic i_service_request,
   input wire logic o_sync,
   input wire logic o_clear_latch_pulse,
   input wire logic o_attention_drive_out,
   input wire logic o_end_identify_line,
   input wire logic o_end_identify_oe,
   input wire logic o_data_valid,
   input wire logic o_data_valid_oe,
   input wire logic o_remote_enable,
   input wire logic o_iface_clear,
   input wire logic o_iface_clear_oe,
   input wire logic o_in_charge_out,
   input wire logic o_special_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sync_period_a: assert property ($rose(o_sync) |-> ##15 $rose(o_sync))
      else $error("sync period is not fifteen clocks");
   clear_pulse_a: assert property ($rose(o_clear_latch_pulse) |->
      o_clear_latch_pulse [*5] ##1 !o_clear_latch_pulse) else $error("clear pulse length wrong");
   clear_sense_a: assert property (i_latched_clear_in && !i_system_controller_switch
      && !o_clear_latch_pulse |-> ##[1:4] o_clear_latch_pulse) else $error("clear not sensed");
   srq_irq_a: assert property (o_in_charge_out && i_service_request
      |-> ##[0:3] o_special_irq) else $error("service request not raised");
   identify_atn_a: assert property (o_end_identify_line |->
      o_attention_drive_out && o_end_identify_oe) else $error("identify without attention");
   poll_dav_a: assert property (o_end_identify_line |-> o_data_valid && o_data_valid_oe)
      else $error("poll without data valid");
   ifc_sysctl_a: assert property (o_iface_clear |-> o_iface_clear_oe ##1 !o_iface_clear)
      else $error("interface clear drive wrong");
   sic_charge_a: assert property (o_iface_clear |-> ##[0:2] o_in_charge_out)
      else $error("not in charge after clear");
   ren_sysctl_a: assert property (o_remote_enable |-> i_system_controller_switch
      || $past(i_system_controller_switch)) else $error("remote enable without switch");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error response outside access phase");
endmodule
bind gpib_controller_function gpib_ctl_properties gpib_ctl_properties_inst (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
   .pslverr(pslverr), .i_latched_clear_in(i_latched_clear_in),
   .i_system_controller_switch(i_system_controller_switch),
   .i_service_request(i_service_request), .o_sync(o_sync),
   .o_clear_latch_pulse(o_clear_latch_pulse), .o_attention_drive_out(o_attention_drive_out),
   .o_end_identify_line(o_end_identify_line), .o_end_identify_oe(o_end_identify_oe),
   .o_data_valid(o_data_valid), .o_data_valid_oe(o_data_valid_oe),
   .o_remote_enable(o_remote_enable), .o_iface_clear(o_iface_clear),
   .o_iface_clear_oe(o_iface_clear_oe), .o_in_charge_out(o_in_charge_out),
   .o_special_irq(o_special_irq));

// [testbench/bus_partner.sv]
// Far-side model: bus attention, poll data-valid release, external clear latch.
// Assumes the bench resolves the data-valid wire from both drivers.
`timescale 1ns/1ps
module bus_partner (
   input  wire logic i_sys_clk,
   input  wire logic i_reset,
   input  wire logic i_slow,
   input  wire logic i_atn_drive,
   input  wire logic i_dv_drive,
   input  wire logic i_clear_pulse,
   input  wire logic i_clear_event,
   output logic      o_atn_seen,
   output logic      o_latched_clear,
   output logic      o_dv_hold
);
   logic [3:0] atn_cnt_q;
   logic [3:0] dv_cnt_q;
   logic       latch_q;
   // Slow mode models a long external attention path
   assign o_atn_seen      = i_atn_drive && (atn_cnt_q >= (i_slow ? 4'hc : 4'h2));
   assign o_dv_hold       = (dv_cnt_q < 4'h8);
   assign o_latched_clear = latch_q;
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         atn_cnt_q <= 4'h0;
         dv_cnt_q  <= 4'h0;
         latch_q   <= 1'b0;
      end else begin
         atn_cnt_q <= i_atn_drive ? atn_cnt_q + {3'h0, atn_cnt_q != 4'hf} : 4'h0;
         dv_cnt_q  <= i_dv_drive ? dv_cnt_q + {3'h0, dv_cnt_q != 4'hf} : 4'h0;
         // Clear pulse wins, so a stale event never survives it
         latch_q   <= i_clear_pulse ? 1'b0 : (latch_q | i_clear_event);
      end
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench: APB register tests and bus-side scenarios.
// Assumes the bus partner model and the bound port checker.
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic        pready, pslverr, err_q, sw = 1'b0, srq = 1'b0, cnt_in = 1'b0;
   logic        slow = 1'b0, clr_ev = 1'b0, atn_seen, lclr, dv_hold, eoi_w, dv_w;
   logic        sync, clp, atn_o, eoi_o, eoi_oe, dv_o, dv_oe, ren, ifc, ifc_oe;
   logic        in_chg, ib_irq, ob_irq, sp_irq, tc_irq, sync_d = 1'b0;
   logic        ifc_seen = 1'b0, pp_seen = 1'b0;
   int          err_count = 0, samples_checked = 0, cyc = 0, rises = 0, rises_base = 0;
   gpib_controller_function gpib_controller_function_inst (
      .i_sys_clk(clk), .i_reset(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .i_latched_clear_in(lclr), .i_attention_monitor_in(atn_seen),
      .i_system_controller_switch(sw), .i_service_request(srq), .i_count(cnt_in),
      .i_end_identify_line(eoi_w), .i_data_valid(dv_w), .o_sync(sync),
      .o_clear_latch_pulse(clp), .o_attention_drive_out(atn_o), .o_end_identify_line(eoi_o),
      .o_end_identify_oe(eoi_oe), .o_data_valid(dv_o), .o_data_valid_oe(dv_oe),
      .o_remote_enable(ren), .o_iface_clear(ifc), .o_iface_clear_oe(ifc_oe),
      .o_in_charge_out(in_chg), .o_input_buffer_empty_irq(ib_irq),
      .o_output_buffer_full_irq(ob_irq), .o_special_irq(sp_irq), .o_task_complete_irq(tc_irq));
   bus_partner bus_partner_inst (
      .i_sys_clk(clk), .i_reset(rst), .i_slow(slow), .i_atn_drive(atn_o),
      .i_dv_drive(dv_o & dv_oe), .i_clear_pulse(clp), .i_clear_event(clr_ev),
      .o_atn_seen(atn_seen), .o_latched_clear(lclr), .o_dv_hold(dv_hold));
   // Released lines float high through the bus pull-ups
   assign eoi_w = eoi_oe ? eoi_o : 1'b1;
   assign dv_w  = (dv_oe ? dv_o : 1'b1) & dv_hold;
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sync_d <= sync;
      if (sync && !sync_d)
         rises <= rises + 1;
      if (ifc)
         ifc_seen <= 1'b1;
      if (eoi_o && atn_o && dv_o)
         pp_seen <= 1'b1;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Ends half a cycle after the transfer so callers see settled outputs
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic rdy;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Answer taken at the same edge that completes the access
      do begin
         @(posedge clk);
         rdy = pready;
         rd_q = prdata;
         err_q = pslverr;
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_q & m, e);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, gpib_ctl_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd_q[2] !== 1'b0 && n < 60);
   endtask
   // Each level outlasts the 45-clock sample gap
   task automatic pulses(input int n);
      repeat (n) begin
         cnt_in <= 1'b1;
         repeat (50) @(posedge clk);
         cnt_in <= 1'b0;
         repeat (50) @(posedge clk);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk(gpib_ctl_pkg::ADDR_MASK, 32'hffffffff, 32'h0);
      rd_chk(gpib_ctl_pkg::ADDR_CTRL, 32'hffffffff, 32'h0);
      rd_chk(8'h1c, 32'hffffffff, 32'h0);
      chk(err_q, 1'b1);
      $display("test reset_map done");
      wr(gpib_ctl_pkg::ADDR_MASK, 32'h03);
      chk(ib_irq, 1'b1);
      wr(gpib_ctl_pkg::ADDR_RESULT, 32'h5a);
      chk(ob_irq, 1'b1);
      rd_chk(gpib_ctl_pkg::ADDR_STATUS, 32'h02, 32'h02);
      rd_chk(gpib_ctl_pkg::ADDR_DATA, 32'hffffffff, 32'h5a);
      chk(ob_irq, 1'b0);
      wr(gpib_ctl_pkg::ADDR_MASK, 32'h00);
      chk(ib_irq, 1'b0);
      $display("test buffers done");
      rises_base = rises;
      repeat (150) @(posedge clk);
      @(negedge clk);
      chk(rises - rises_base, 32'd10);
      wr(gpib_ctl_pkg::ADDR_CTRL, 32'h01);
      pulses(4);
      rd_chk(gpib_ctl_pkg::ADDR_COUNT, 32'hffff, 32'h4);
      wr(gpib_ctl_pkg::ADDR_CTRL, 32'h00);
      pulses(2);
      rd_chk(gpib_ctl_pkg::ADDR_COUNT, 32'hffff, 32'h4);
      $display("test sync_count done");
      @(posedge clk);
      sw <= 1'b1;
      wr(gpib_ctl_pkg::ADDR_CTRL, 32'h22);
      wait_idle();
      chk(ifc_seen, 1'b1);
      chk({in_chg, ren}, 2'b11);
      rd_chk(gpib_ctl_pkg::ADDR_STATUS, 32'h18, 32'h18);
      @(posedge clk);
      srq <= 1'b1;
      repeat (4) @(posedge clk);
      srq <= 1'b0;
      @(negedge clk);
      chk(sp_irq, 1'b1);
      rd_chk(gpib_ctl_pkg::ADDR_STATUS, 32'h20, 32'h20);
      chk(sp_irq, 1'b0);
      $display("test in_charge done");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         slow <= k[0];
         wr(gpib_ctl_pkg::ADDR_CTRL, k[0] ? 32'h08 : 32'h04);
         wait_idle();
         chk(tc_irq, 1'b1);
         rd_chk(gpib_ctl_pkg::ADDR_DATA, 32'h08, 32'h08);
         chk(tc_irq, 1'b0);
      end
      wr(gpib_ctl_pkg::ADDR_CTRL, 32'h10);
      wait_idle();
      chk(pp_seen, 1'b1);
      $display("test take_poll done");
      @(posedge clk);
      sw <= 1'b0;
      clr_ev <= 1'b1;
      @(posedge clk);
      clr_ev <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk(gpib_ctl_pkg::ADDR_STATUS, 32'h40, 32'h40);
      chk(lclr, 1'b0);
      $display("test clear_sense done");
      test_done();
   end
endmodule
